// ===== logic/iil_cfg.svh
// Timing constants of the issue latency model.
// Notes on behaviour
// RULE_01 - ALU ops: 1 unshifted, 2 immediate shift, 3 register shift.
// RULE_02 - Saturating and halving add/subtract: 2 cycles, unshifted only.
// RULE_03 - Doubling saturating add/subtract and single saturate take 3 cycles.
// RULE_04 - Dual-halfword saturate and plain parallel add/subtract take 1 cycle.
// RULE_05 - Extend-and-add on bytes, dual bytes or halfwords takes 3 cycles.
// RULE_06 - Plain sign or zero extend takes 2 cycles.
// RULE_07 - Bitfield clear, insert and extract take 2 cycles.
// RULE_08 - Leading zeros, move-top, move-wide, reverses, status read take 1 cycle.
// RULE_09 - Status write not touching mode or control takes 1 cycle; others serialize.
// RULE_10 - Load data forwards only into add/subtract/compare/move-not ops.
// RULE_11 - No fast forward when the forwarded register feeds a shift.
// RULE_12 - Simple word load: 1 address cycle, latency 2 fast, 3 otherwise.
// RULE_13 - Word load with register shift or extend-rotate: 1 cycle, latency 3 or 4.
// RULE_14 - Simple byte or halfword load: 2 address cycles, latency 3 or 4.
// RULE_15 - Register-shifted byte or halfword load: 2 address cycles, latency 4 or 5.
// RULE_16 - Single load latency counts to the first destination register.
// RULE_17 - Two 32-bit registers move per cycle only at 64-bit aligned addresses.
// RULE_18 - Multiple transfers take cycles from list length and start alignment.
// RULE_19 - Load-multiple latency refers to the first loaded register.
// RULE_20 - Serializing operations wait until all earlier results are written.
// RULE_21 - Each destination keeps a ready count; dependents stall until it expires.
// RULE_22 - Register move: 1 cycle unshifted or immediate shift, 2 register shift.
`ifndef IIL_CFG_SVH
`define IIL_CFG_SVH

`define IIL_CNT_W      4
`define IIL_REG_W      4
`define IIL_NREG       16
`define IIL_LEN_W      5
`define IIL_ALIGN_MASK 3'h7

`define IIL_C1         4'h1
`define IIL_C2         4'h2
`define IIL_C3         4'h3

`define IIL_AGU_WORD   4'h1
`define IIL_AGU_BH     4'h2
`define IIL_LAT_WS_F   4'h2
`define IIL_LAT_WS_O   4'h3
`define IIL_LAT_WR_F   4'h3
`define IIL_LAT_WR_O   4'h4
`define IIL_LAT_BS_F   4'h3
`define IIL_LAT_BS_O   4'h4
`define IIL_LAT_BR_F   4'h4
`define IIL_LAT_BR_O   4'h5
`define IIL_LAT_LM_F   4'h2
`define IIL_LAT_LM_O   4'h3
`define IIL_SERIAL_CYC 4'h1

`endif

// ===== logic/iil_core.sv
// Issue-stage cycle accounting.
`timescale 1ns/10ps
`default_nettype none
`include "iil_cfg.svh"

module iil_core #(
    parameter int NREG  = `IIL_NREG,
    parameter int CNT_W = `IIL_CNT_W
) (
    input  wire logic                  clk_sys_in,       // Core clock, 125 MHz.
    input  wire logic                  rst_n_in,         // Synchronous reset, active low.
    input  wire logic                  issue_valid_in,   // Offered.
    output logic                       issue_ready_out,  // Taken this cycle.
    input  wire iil_pkg::iil_op_e      op_class_in,      // Operation class.
    input  wire iil_pkg::iil_shift_e   shift_kind_in,    // Shift style.
    input  wire logic                  dst_use_in,       // Writes a register.
    input  wire logic [`IIL_REG_W-1:0] dst_reg_in,       // First destination register.
    input  wire logic                  src_a_use_in,     // Unshifted source is read.
    input  wire logic [`IIL_REG_W-1:0] src_a_reg_in,     // Unshifted source register.
    input  wire logic                  src_b_use_in,     // Shiftable source is read.
    input  wire logic [`IIL_REG_W-1:0] src_b_reg_in,     // Shiftable source register.
    input  wire logic                  sh_amt_use_in,    // Shift amount is read.
    input  wire logic [`IIL_REG_W-1:0] sh_amt_reg_in,    // Shift amount register.
    input  wire logic                  mode_write_in,    // Write alters mode bits.
    input  wire logic [`IIL_LEN_W-1:0] reg_count_in,     // Register list length, 1 to 16.
    input  wire logic [2:0]            addr_low_in,      // Low bits of the start address.
    output logic                       issued_out,       // Issue pulse.
    output logic [CNT_W-1:0]           exec_cycles_out,  // Its exec cycles.
    output logic [CNT_W-1:0]           agu_cycles_out,   // Its address cycles.
    output logic [CNT_W-1:0]           result_lat_out,   // First result latency.
    output logic                       pair_used_out,    // It moved register pairs.
    output logic                       dep_stall_out,    // Waiting on a source register.
    output logic                       unit_stall_out,   // Waiting on a busy unit.
    output logic                       drain_out         // Waiting for a serialized drain.
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding functions.

    function automatic logic [CNT_W-1:0] exec_cyc(
        input iil_pkg::iil_op_e    cls,
        input iil_pkg::iil_shift_e sk,
        input logic                mw
    );
        logic [CNT_W-1:0] c;
        c = CNT_W'(0);
        unique case (cls)
            // RULE_22 move occupancy
            iil_pkg::IIL_OP_MOVE:
                c = (sk == iil_pkg::IIL_SH_REG) ? CNT_W'(`IIL_C2) : CNT_W'(`IIL_C1);
            // RULE_01 shift-dependent occupancy
            iil_pkg::IIL_OP_ALU_FWD,
            iil_pkg::IIL_OP_ALU_LOG: begin
                unique case (sk)
                    iil_pkg::IIL_SH_IMM: c = CNT_W'(`IIL_C2);
                    iil_pkg::IIL_SH_REG: c = CNT_W'(`IIL_C3);
                    default:             c = CNT_W'(`IIL_C1);
                endcase
            end
            iil_pkg::IIL_OP_PACK:
                c = (sk == iil_pkg::IIL_SH_NONE) ? CNT_W'(`IIL_C1) : CNT_W'(`IIL_C2);
            // RULE_02 saturating parallel ops
            iil_pkg::IIL_OP_SAT2:   c = CNT_W'(`IIL_C2);
            // RULE_03 doubling and single saturate
            iil_pkg::IIL_OP_SAT3:   c = CNT_W'(`IIL_C3);
            // RULE_04 plain parallel ops
            iil_pkg::IIL_OP_SIMD1:  c = CNT_W'(`IIL_C1);
            // RULE_05 extend and add
            iil_pkg::IIL_OP_EXTADD: c = CNT_W'(`IIL_C3);
            // RULE_06 plain extend
            iil_pkg::IIL_OP_EXT:    c = CNT_W'(`IIL_C2);
            // RULE_07 bitfield ops
            iil_pkg::IIL_OP_BITFLD: c = CNT_W'(`IIL_C2);
            // RULE_08 single cycle misc
            iil_pkg::IIL_OP_MISC1,
            iil_pkg::IIL_OP_SR_READ: c = CNT_W'(`IIL_C1);
            // RULE_09 status write cost
            iil_pkg::IIL_OP_SR_WRITE:
                c = mw ? CNT_W'(`IIL_SERIAL_CYC) : CNT_W'(`IIL_C1);
            iil_pkg::IIL_OP_SERIAL: c = CNT_W'(`IIL_SERIAL_CYC);
            default:                c = CNT_W'(0);
        endcase
        return c;
    endfunction

    // RULE_17 pairs need 64-bit alignment
    function automatic logic [CNT_W-1:0] pair_cyc(
        input logic [`IIL_LEN_W-1:0] n,
        input logic                  al
    );
        logic [`IIL_LEN_W-1:0] m;
        logic [`IIL_LEN_W-1:0] r;
        m = (n == '0) ? `IIL_LEN_W'(1) : n;
        if (al) begin
            r = `IIL_LEN_W'((m + `IIL_LEN_W'(1)) >> 1);
        end else begin
            r = `IIL_LEN_W'((m >> 1) + `IIL_LEN_W'(1));
        end
        return CNT_W'(r);
    endfunction

    // Load result latency; fast picks forwarding.
    function automatic logic [CNT_W-1:0] load_lat(
        input iil_pkg::iil_op_e    cls,
        input iil_pkg::iil_shift_e sk,
        input logic                fast
    );
        logic [CNT_W-1:0] l;
        logic             rs;
        rs = (sk == iil_pkg::IIL_SH_REG);
        l  = CNT_W'(0);
        unique case (cls)
            // RULE_12 RULE_13 word load latency
            iil_pkg::IIL_OP_LD_WORD: begin
                if (rs) begin
                    l = fast ? CNT_W'(`IIL_LAT_WR_F) : CNT_W'(`IIL_LAT_WR_O);
                end else begin
                    l = fast ? CNT_W'(`IIL_LAT_WS_F) : CNT_W'(`IIL_LAT_WS_O);
                end
            end
            // RULE_14 RULE_15 byte and halfword latency
            iil_pkg::IIL_OP_LD_BH: begin
                if (rs) begin
                    l = fast ? CNT_W'(`IIL_LAT_BR_F) : CNT_W'(`IIL_LAT_BR_O);
                end else begin
                    l = fast ? CNT_W'(`IIL_LAT_BS_F) : CNT_W'(`IIL_LAT_BS_O);
                end
            end
            // RULE_19 first loaded register
            iil_pkg::IIL_OP_LD_MULTI:
                l = fast ? CNT_W'(`IIL_LAT_LM_F) : CNT_W'(`IIL_LAT_LM_O);
            default: l = CNT_W'(0);
        endcase
        return l;
    endfunction

    function automatic logic is_load(input iil_pkg::iil_op_e cls);
        return (cls == iil_pkg::IIL_OP_LD_WORD) || (cls == iil_pkg::IIL_OP_LD_BH)
            || (cls == iil_pkg::IIL_OP_LD_MULTI);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Offer decode.

    logic             aligned;
    logic             uses_agu;
    logic             uses_exec;
    logic             serial;
    logic             fwd_class;
    logic [CNT_W-1:0] cur_exec;
    logic [CNT_W-1:0] cur_agu;
    logic [CNT_W-1:0] cur_lat_f;
    logic [CNT_W-1:0] cur_lat_o;

    assign aligned   = (addr_low_in & `IIL_ALIGN_MASK) == 3'h0;
    assign uses_agu  = is_load(op_class_in) || (op_class_in == iil_pkg::IIL_OP_ST_MULTI);
    assign uses_exec = !uses_agu;
    // RULE_09 mode-altering write serializes
    assign serial    = (op_class_in == iil_pkg::IIL_OP_SERIAL)
                    || ((op_class_in == iil_pkg::IIL_OP_SR_WRITE) && mode_write_in);
    // RULE_10 forwarding consumer classes
    assign fwd_class = (op_class_in == iil_pkg::IIL_OP_ALU_FWD);
    assign cur_exec  = exec_cyc(op_class_in, shift_kind_in, mode_write_in);
    assign cur_lat_f = load_lat(op_class_in, shift_kind_in, 1'b1);
    assign cur_lat_o = load_lat(op_class_in, shift_kind_in, 1'b0);

    // RULE_18 address cycles per class
    always_comb begin
        unique case (op_class_in)
            iil_pkg::IIL_OP_LD_WORD:  cur_agu = CNT_W'(`IIL_AGU_WORD);
            iil_pkg::IIL_OP_LD_BH:    cur_agu = CNT_W'(`IIL_AGU_BH);
            iil_pkg::IIL_OP_LD_MULTI,
            iil_pkg::IIL_OP_ST_MULTI: cur_agu = pair_cyc(reg_count_in, aligned);
            default:                  cur_agu = CNT_W'(0);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-register ready counters.

    logic [CNT_W-1:0] rem_fast_ff [NREG];
    logic [CNT_W-1:0] rem_slow_ff [NREG];
    logic [NREG-1:0]  busy_vec;
    logic             take;
    logic [CNT_W-1:0] new_fast;
    logic [CNT_W-1:0] new_slow;

    // RULE_16 latency of the first destination
    assign new_fast = is_load(op_class_in) ? cur_lat_f - CNT_W'(1) : cur_exec - CNT_W'(1);
    assign new_slow = is_load(op_class_in) ? cur_lat_o - CNT_W'(1) : cur_exec - CNT_W'(1);

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            // RULE_21 ready count per register
            always_ff @(posedge clk_sys_in) begin
                if (!rst_n_in) begin
                    rem_fast_ff[gi] <= '0;
                    rem_slow_ff[gi] <= '0;
                end else if (take && dst_use_in && (dst_reg_in == `IIL_REG_W'(gi))) begin
                    rem_fast_ff[gi] <= new_fast;
                    rem_slow_ff[gi] <= new_slow;
                end else begin
                    if (rem_fast_ff[gi] != '0) begin
                        rem_fast_ff[gi] <= rem_fast_ff[gi] - CNT_W'(1);
                    end
                    if (rem_slow_ff[gi] != '0) begin
                        rem_slow_ff[gi] <= rem_slow_ff[gi] - CNT_W'(1);
                    end
                end
            end
            assign busy_vec[gi] = rem_slow_ff[gi] != '0;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Dependence check.

    logic dep_a;
    logic dep_b;
    logic dep_s;

    // RULE_10 RULE_11 unshifted source may forward
    assign dep_a = src_a_use_in && (fwd_class ? rem_fast_ff[src_a_reg_in] != '0
                                              : rem_slow_ff[src_a_reg_in] != '0);
    // RULE_11 shifted source takes slow path
    assign dep_b = src_b_use_in
                && ((fwd_class && (shift_kind_in == iil_pkg::IIL_SH_NONE))
                    ? rem_fast_ff[src_b_reg_in] != '0
                    : rem_slow_ff[src_b_reg_in] != '0);
    assign dep_s = sh_amt_use_in && (rem_slow_ff[sh_amt_reg_in] != '0);

    ////////////////////////////////////////////////////////////////////////////
    // Unit occupancy.

    logic [CNT_W-1:0] exec_cnt_ff;
    logic [CNT_W-1:0] agu_cnt_ff;
    logic             unit_busy;
    logic             all_idle;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            exec_cnt_ff <= '0;
        end else if (take && uses_exec) begin
            exec_cnt_ff <= cur_exec - CNT_W'(1);
        end else if (exec_cnt_ff != '0) begin
            exec_cnt_ff <= exec_cnt_ff - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            agu_cnt_ff <= '0;
        end else if (take && uses_agu) begin
            agu_cnt_ff <= cur_agu - CNT_W'(1);
        end else if (agu_cnt_ff != '0) begin
            agu_cnt_ff <= agu_cnt_ff - CNT_W'(1);
        end
    end

    assign unit_busy = uses_exec ? (exec_cnt_ff != '0) : (agu_cnt_ff != '0);
    // Forwarded results still count as unfinished for a serializing op.
    assign all_idle  = (busy_vec == '0) && (exec_cnt_ff == '0) && (agu_cnt_ff == '0);

    ////////////////////////////////////////////////////////////////////////////
    // Serialization.

    iil_pkg::iil_state_e state_ff;

    // RULE_20 drain before serializing
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state_ff <= iil_pkg::IIL_ST_RUN;
        end else begin
            unique case (state_ff)
                iil_pkg::IIL_ST_RUN: begin
                    if (issue_valid_in && serial && !all_idle) begin
                        state_ff <= iil_pkg::IIL_ST_DRAIN;
                    end
                end
                iil_pkg::IIL_ST_DRAIN: begin
                    if (all_idle) begin
                        state_ff <= iil_pkg::IIL_ST_RUN;
                    end
                end
                default: state_ff <= iil_pkg::IIL_ST_RUN;
            endcase
        end
    end

    logic in_run;

    assign in_run          = state_ff == iil_pkg::IIL_ST_RUN;
    assign dep_stall_out   = issue_valid_in && (dep_a || dep_b || dep_s);
    assign unit_stall_out  = issue_valid_in && unit_busy;
    assign drain_out       = state_ff == iil_pkg::IIL_ST_DRAIN;
    // RULE_20 RULE_21 issue gating
    assign take            = issue_valid_in && in_run && !unit_busy
                          && !(dep_a || dep_b || dep_s) && !(serial && !all_idle);
    assign issue_ready_out = take;

    ////////////////////////////////////////////////////////////////////////////
    // Issue report.

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            issued_out <= 1'b0;
        end else begin
            issued_out <= take;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            exec_cycles_out <= '0;
            agu_cycles_out  <= '0;
            result_lat_out  <= '0;
            pair_used_out   <= 1'b0;
        end else if (take) begin
            exec_cycles_out <= uses_exec ? cur_exec : CNT_W'(0);
            agu_cycles_out  <= cur_agu;
            result_lat_out  <= is_load(op_class_in) ? cur_lat_o : cur_exec;
            // RULE_17 paired transfer flag
            pair_used_out   <= (reg_count_in > (aligned ? `IIL_LEN_W'(1) : `IIL_LEN_W'(2)))
                            && ((op_class_in == iil_pkg::IIL_OP_LD_MULTI)
                                || (op_class_in == iil_pkg::IIL_OP_ST_MULTI));
        end
    end

endmodule
`default_nettype wire

// ===== logic/iil_pkg.sv
// Shared types of the issue latency model.
`default_nettype none
package iil_pkg;

    typedef enum logic [4:0] {
        IIL_OP_MOVE     = 5'h00,
        IIL_OP_ALU_FWD  = 5'h01,
        IIL_OP_ALU_LOG  = 5'h02,
        IIL_OP_PACK     = 5'h03,
        IIL_OP_SAT2     = 5'h04,
        IIL_OP_SAT3     = 5'h05,
        IIL_OP_SIMD1    = 5'h06,
        IIL_OP_EXTADD   = 5'h07,
        IIL_OP_EXT      = 5'h08,
        IIL_OP_BITFLD   = 5'h09,
        IIL_OP_MISC1    = 5'h0A,
        IIL_OP_SR_READ  = 5'h0B,
        IIL_OP_SR_WRITE = 5'h0C,
        IIL_OP_LD_WORD  = 5'h0D,
        IIL_OP_LD_BH    = 5'h0E,
        IIL_OP_LD_MULTI = 5'h0F,
        IIL_OP_ST_MULTI = 5'h10,
        IIL_OP_SERIAL   = 5'h11
    } iil_op_e;

    typedef enum logic [1:0] {
        IIL_SH_NONE = 2'h0,
        IIL_SH_IMM  = 2'h1,
        IIL_SH_REG  = 2'h2
    } iil_shift_e;

    typedef enum logic [1:0] {
        IIL_ST_RUN   = 2'h1,
        IIL_ST_DRAIN = 2'h2
    } iil_state_e;

endpackage
`default_nettype wire

// ===== tb/iil_core_assertions.sv
// Port assertions of the issue latency model.
`timescale 1ns/10ps
`default_nettype none
`include "iil_cfg.svh"

module iil_core_assertions #(
    parameter int CNT_W = `IIL_CNT_W
) (
    input wire logic                  clk_sys_in,      // Core clock.
    input wire logic                  rst_n_in,        // Reset, active low.
    input wire logic                  issue_valid_in,  // Offer.
    input wire logic                  issue_ready_out, // Take.
    input wire iil_pkg::iil_op_e      op_class_in,     // Class.
    input wire iil_pkg::iil_shift_e   shift_kind_in,   // Shift style.
    input wire logic                  mode_write_in,   // Mode write.
    input wire logic [`IIL_LEN_W-1:0] reg_count_in,    // List length.
    input wire logic [2:0]            addr_low_in,     // Address bits.
    input wire logic                  issued_out,      // Issue pulse.
    input wire logic [CNT_W-1:0]      exec_cycles_out, // Exec cycles.
    input wire logic [CNT_W-1:0]      agu_cycles_out,  // Address cycles.
    input wire logic [CNT_W-1:0]      result_lat_out,  // Latency.
    input wire logic                  drain_out        // Drain wait.
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    logic             take;
    logic [CNT_W-1:0] exp_agu;
    assign take = issue_valid_in && issue_ready_out;
    // Misaligned: one single register, then pairs.
    assign exp_agu = (addr_low_in == 3'h0) ? CNT_W'((reg_count_in + 5'h01) >> 1)
                                           : CNT_W'((reg_count_in >> 1) + 5'h01);

    property p_take_report;
        take |=> issued_out;
    endproperty
    a_take_report: assert property (p_take_report) else $error("no issue pulse after take");
    property p_drain_blocks;
        drain_out |-> !issue_ready_out;
    endproperty
    a_drain_blocks: assert property (p_drain_blocks) else $error("take while draining");
    property p_alu_exec;
        take && op_class_in inside {iil_pkg::IIL_OP_ALU_FWD, iil_pkg::IIL_OP_ALU_LOG} |=> exec_cycles_out ==
            (($past(shift_kind_in) == iil_pkg::IIL_SH_NONE) ? 4'h1 : ($past(shift_kind_in) == iil_pkg::IIL_SH_IMM) ? 4'h2 : 4'h3);
    endproperty
    a_alu_exec: assert property (p_alu_exec) else $error("alu exec cycles wrong");
    property p_alu_busy;
        take && op_class_in == iil_pkg::IIL_OP_ALU_LOG && shift_kind_in == iil_pkg::IIL_SH_REG
            |=> !(take && op_class_in == iil_pkg::IIL_OP_ALU_LOG) [*2];
    endproperty
    a_alu_busy: assert property (p_alu_busy) else $error("exec unit reused too early");
    property p_move_exec;
        take && op_class_in == iil_pkg::IIL_OP_MOVE
            |=> exec_cycles_out == (($past(shift_kind_in) == iil_pkg::IIL_SH_REG) ? 4'h2 : 4'h1);
    endproperty
    a_move_exec: assert property (p_move_exec) else $error("move exec cycles wrong");
    property p_word_load;
        take && op_class_in == iil_pkg::IIL_OP_LD_WORD |=> agu_cycles_out == 4'h1 &&
            result_lat_out == (($past(shift_kind_in) == iil_pkg::IIL_SH_REG) ? 4'h4 : 4'h3);
    endproperty
    a_word_load: assert property (p_word_load) else $error("word load timing wrong");
    property p_bh_load;
        take && op_class_in == iil_pkg::IIL_OP_LD_BH |=> agu_cycles_out == 4'h2 &&
            result_lat_out == (($past(shift_kind_in) == iil_pkg::IIL_SH_REG) ? 4'h5 : 4'h4);
    endproperty
    a_bh_load: assert property (p_bh_load) else $error("byte load timing wrong");
    property p_multi;
        take && op_class_in inside {iil_pkg::IIL_OP_LD_MULTI, iil_pkg::IIL_OP_ST_MULTI} && reg_count_in != 5'h00
            |=> agu_cycles_out == $past(exp_agu);
    endproperty
    a_multi: assert property (p_multi) else $error("multiple transfer cycles wrong");
    property p_status_write;
        take && op_class_in == iil_pkg::IIL_OP_SR_WRITE && !mode_write_in |=> exec_cycles_out == 4'h1;
    endproperty
    a_status_write: assert property (p_status_write) else $error("status write cycles wrong");
endmodule

bind iil_core iil_core_assertions #(.CNT_W(CNT_W)) i_chk (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .issue_valid_in(issue_valid_in),
    .issue_ready_out(issue_ready_out), .op_class_in(op_class_in), .shift_kind_in(shift_kind_in),
    .mode_write_in(mode_write_in), .reg_count_in(reg_count_in), .addr_low_in(addr_low_in),
    .issued_out(issued_out), .exec_cycles_out(exec_cycles_out), .agu_cycles_out(agu_cycles_out),
    .result_lat_out(result_lat_out), .drain_out(drain_out)
);
`default_nettype wire

// ===== tb/iil_core_test.sv
// Self-checking bench of the issue model.
`timescale 1ns/10ps
`default_nettype none
module iil_core_test;
    logic                clk_sys_in     = 1'b0;
    logic                rst_n_in       = 1'b0;
    logic                issue_valid_in = 1'b0;
    iil_pkg::iil_op_e    op_class_in    = iil_pkg::IIL_OP_MOVE;
    iil_pkg::iil_shift_e shift_kind_in  = iil_pkg::IIL_SH_NONE;
    logic                dst_use_in = 1'b0, src_a_use_in = 1'b0, src_b_use_in = 1'b0, sh_amt_use_in = 1'b0;
    logic                mode_write_in  = 1'b0;
    logic [3:0]          dst_reg_in = 4'h0, src_a_reg_in = 4'h0, src_b_reg_in = 4'h0, sh_amt_reg_in = 4'h0;
    logic [4:0]          reg_count_in   = 5'h01;
    logic [2:0]          addr_low_in    = 3'h0;
    logic                issue_ready_out, issued_out, pair_used_out, dep_stall_out, unit_stall_out, drain_out;
    logic [3:0]          exec_cycles_out, agu_cycles_out, result_lat_out;
    logic                drain_seen     = 1'b0;
    logic [1:0]          stl;
    int                  err_count      = 0;
    int                  n_tests        = 0;
    int                  st;

    iil_core i_dut (.clk_sys_in, .rst_n_in, .issue_valid_in, .issue_ready_out, .op_class_in, .shift_kind_in,
        .dst_use_in, .dst_reg_in, .src_a_use_in, .src_a_reg_in, .src_b_use_in, .src_b_reg_in, .sh_amt_use_in,
        .sh_amt_reg_in, .mode_write_in, .reg_count_in, .addr_low_in, .issued_out, .exec_cycles_out,
        .agu_cycles_out, .result_lat_out, .pair_used_out, .dep_stall_out, .unit_stall_out, .drain_out);

    always #4 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) if (drain_out === 1'b1) drain_seen <= 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic idle(input int n);
        issue_valid_in = 1'b0;
        repeat (n) @(negedge clk_sys_in);
    endtask

    // st counts refused cycles; register 0 means unused.
    task automatic issue(input logic [4:0] op, input logic [1:0] sh, input logic [3:0] dst, input logic [3:0] ra,
                         input logic [3:0] rb, input logic [4:0] cnt = 5'h01, input logic [2:0] al = 3'h0,
                         input logic mw = 1'b0);
        op_class_in    = iil_pkg::iil_op_e'(op);
        shift_kind_in  = iil_pkg::iil_shift_e'(sh);
        dst_use_in     = (dst != 4'h0);
        dst_reg_in     = dst;
        src_a_use_in   = (ra != 4'h0);
        src_a_reg_in   = ra;
        src_b_use_in   = (rb != 4'h0);
        src_b_reg_in   = rb;
        sh_amt_use_in  = (sh == 2'h2) && (rb != 4'h0);
        sh_amt_reg_in  = rb;
        mode_write_in  = mw;
        reg_count_in   = cnt;
        addr_low_in    = al;
        issue_valid_in = 1'b1;
        stl            = 2'h0;
        #1;
        for (st = 0; st < 40 && issue_ready_out !== 1'b1; st++) begin
            stl |= {unit_stall_out, dep_stall_out};
            @(negedge clk_sys_in);
            #1;
        end
        if (st == 40) begin
            err_count++;
            $display("CHECK FAILED take expected 1 seen 0");
            summarize();
        end
        @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check_val("issued", 8'h01, {7'h0, issued_out});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Entries: class, shift, expected cycles.
    task automatic t_exec();
        logic [15:0] tab [20] = '{16'h0001, 16'h0011, 16'h0022, 16'h0101, 16'h0112, 16'h0123, 16'h0201,
            16'h0212, 16'h0223, 16'h0301, 16'h0312, 16'h0402, 16'h0503, 16'h0601, 16'h0703, 16'h0802,
            16'h0902, 16'h0A01, 16'h0B01, 16'h0C01};
        foreach (tab[i]) begin
            idle(4);
            issue(tab[i][12:8], tab[i][5:4], 4'h0, 4'h0, 4'h0);
            check_val("exec", {4'h0, tab[i][3:0]}, {4'h0, exec_cycles_out});
        end
        issue(5'h02, 2'h2, 4'h0, 4'h0, 4'h0);
        issue(5'h02, 2'h0, 4'h0, 4'h0, 4'h0);
        check_val("alu busy", 8'h22, {2'h0, stl, 4'(st)});
        issue(5'h00, 2'h2, 4'h0, 4'h0, 4'h0);
        issue(5'h00, 2'h0, 4'h0, 4'h0, 4'h0);
        check_val("move busy", 8'h01, 8'(st));
    endtask

    // Consumers: class, shift, refused cycles.
    task automatic t_loads();
        logic [15:0] con [5] = '{16'h0101, 16'h0202, 16'h0002, 16'h0112, 16'h0122};
        for (int k = 0; k < 4; k++) begin
            idle(6);
            issue(k[1] ? 5'h0E : 5'h0D, {k[0], 1'b0}, 4'h5, 4'h0, 4'h0);
            check_val("agu", 8'(1 + k[1]), {4'h0, agu_cycles_out});
            check_val("lat", 8'(3 + k[1] + k[0]), {4'h0, result_lat_out});
            issue(5'h01, 2'h0, 4'h6, 4'h5, 4'h0);
            check_val("fast wait", 8'(17 + k[1] + k[0]), {2'h0, stl, 4'(st)});
        end
        foreach (con[i]) begin
            idle(6);
            issue(5'h0D, 2'h0, 4'h5, 4'h0, 4'h0);
            issue(con[i][12:8], con[i][5:4], 4'h6, 4'h0, 4'h5);
            check_val("dep wait", {4'h0, con[i][3:0]}, 8'(st));
        end
    endtask

    task automatic t_multi();
        int e;
        for (int n = 1; n <= 16; n++) begin
            for (int a = 0; a < 4; a++) begin
                e = a[1] ? n / 2 + 1 : (n + 1) / 2;
                issue(a[0] ? 5'h0F : 5'h10, 2'h0, a[0] ? 4'h7 : 4'h0, 4'h0, 4'h0, 5'(n), a[1] ? 3'h4 : 3'h0);
                check_val("agu multi", 8'(e), {4'h0, agu_cycles_out});
                check_val("pair", 8'(e != n), {7'h0, pair_used_out});
            end
        end
        idle(12);
        issue(5'h0F, 2'h0, 4'h8, 4'h0, 4'h0, 5'h10, 3'h0);
        issue(5'h01, 2'h0, 4'h9, 4'h8, 4'h0);
        check_val("multi fast", 8'h01, 8'(st));
    endtask

    // Serial ops wait for slow loads in flight.
    task automatic t_serial();
        idle(6);
        issue(5'h0E, 2'h2, 4'hA, 4'h0, 4'h0);
        issue(5'h11, 2'h0, 4'h0, 4'h0, 4'h0);
        check_val("serial wait", 8'h01, 8'(st >= 4));
        check_val("drain", 8'h01, {7'h0, drain_seen});
        idle(6);
        issue(5'h0D, 2'h0, 4'hB, 4'h0, 4'h0);
        issue(5'h0C, 2'h0, 4'h0, 4'h0, 4'h0, 5'h01, 3'h0, 1'b1);
        check_val("mode write wait", 8'h01, 8'(st >= 2));
    endtask

    initial begin
        repeat (10) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        t_exec();
        t_loads();
        t_multi();
        t_serial();
        idle(2);
        summarize();
    end
endmodule
`default_nettype wire
